// ### hdl/adcsc_consts.svh
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// Register byte offsets
`define ADCSC_CTRL_OFS 8'h00
`define ADCSC_DONE_OFS 8'h04
`define ADCSC_CONV_OFS 8'h08

// Control and done register field positions
`define ADCSC_BIT_LJST 0
`define ADCSC_BIT_WIN 1
`define ADCSC_BIT_SRC_LO 2
`define ADCSC_BIT_SRC_HI 3
`define ADCSC_BIT_BUSY 4
`define ADCSC_BIT_TRACK 5
`define ADCSC_BIT_DONE 0

// Reset values
`define ADCSC_SRC_RESET 2'h0
`define ADCSC_CONV_CYC_RESET 8'h10

// Tracking lasts this many converter clocks
`define ADCSC_TRACK_CLOCKS 2'h3

`endif

// ### hdl/adcsc_pkg.sv
package adcsc_pkg;
    // Conversion sequencer states, one-hot
    typedef enum logic [3:0] {
        ADCSC_IDLE = 4'h1,
        ADCSC_TRACK = 4'h2,
        ADCSC_GATE = 4'h4,
        ADCSC_CONV = 4'h8
    } adcsc_state_t;

    // Start-source codes
    typedef enum logic [1:0] {
        ADCSC_SRC_SW = 2'h0,
        ADCSC_SRC_T3 = 2'h1,
        ADCSC_SRC_PIN = 2'h2,
        ADCSC_SRC_T2 = 2'h3
    } adcsc_src_t;
endpackage

// ### hdl/adcsc_sync.sv
`include "adcsc_consts.svh"
// Three-flop synchroniser with agreement of the last two stages
module adcsc_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } adcsc_sync_st_t;

    adcsc_sync_st_t st_reg; // All state
    adcsc_sync_st_t st_next; // Next state

    // First stage is read only by the second
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin // Change counts once they agree
            st_next.level = st_reg.s3;
        end
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Reset to the idle-high level so that release brings no false edge
            st_reg <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.level;
endmodule // adcsc_sync

// ### hdl/adcsc_top.sv
`include "adcsc_consts.svh"
module adcsc_top
    import adcsc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sar_clk_tick,
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire logic external_convert_start,
    input wire logic window_match,
    output logic tracking_active,
    output logic conversion_start,
    output logic conversion_busy_flag,
    output logic conversion_done_flag,
    output logic window_match_flag,
    output logic left_justify_select
);
    // All state of the block
    typedef struct packed {
        adcsc_state_t state;
        logic [1:0] start_source_field;
        logic tracking_mode_select;
        logic window_flag;
        logic ljst;
        logic done_flag;
        logic [7:0] conv_cycles;
        logic [7:0] conv_cnt;
        logic [1:0] track_cnt;
        logic pin_prev;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic start_pulse;
        logic tracking;
    } adcsc_st_t;

    adcsc_st_t st_reg; // Registered state
    adcsc_st_t st_next; // Next state
    logic pin_level; // Synchronised start pin
    logic pin_rise; // Rising edge of the pin
    logic addr_ok; // Address phase accepted
    logic sw_start; // Software busy write of one
    logic trig; // Selected trigger event

    // Pin goes through the three-flop synchroniser first
    adcsc_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(external_convert_start),
        .sync_out(pin_level)
    );

    // Next-state logic: bus slave, flags and sequencer
    always_comb begin
        st_next = st_reg;
        st_next.start_pulse = 1'b0;
        addr_ok = hsel && hready && htrans[1];
        pin_rise = pin_level && !st_reg.pin_prev;
        st_next.pin_prev = pin_level;
        sw_start = 1'b0;
        // Address phase captured; data handled next cycle
        if (addr_ok) begin
            st_next.wr_pend = hwrite;
            st_next.wr_addr = haddr[7:0];
        end else begin
            st_next.wr_pend = 1'b0;
        end
        // Read data prepared in the address phase, zero when unmapped
        if (addr_ok && !hwrite) begin
            st_next.rdata = 32'h0;
            unique case (haddr[7:0])
                `ADCSC_CTRL_OFS: begin
                    st_next.rdata[`ADCSC_BIT_LJST] = st_reg.ljst;
                    st_next.rdata[`ADCSC_BIT_WIN] = st_reg.window_flag;
                    st_next.rdata[`ADCSC_BIT_SRC_HI:`ADCSC_BIT_SRC_LO] =
                        st_reg.start_source_field;
                    st_next.rdata[`ADCSC_BIT_BUSY] = st_reg.state[3];
                    st_next.rdata[`ADCSC_BIT_TRACK] = st_reg.tracking_mode_select;
                end
                `ADCSC_DONE_OFS: begin
                    st_next.rdata[`ADCSC_BIT_DONE] = st_reg.done_flag;
                end
                `ADCSC_CONV_OFS: begin
                    st_next.rdata[7:0] = st_reg.conv_cycles;
                end
                default: begin
                    st_next.rdata = 32'h0;
                end
            endcase
        end
        // Write data phase
        if (st_reg.wr_pend) begin
            unique case (st_reg.wr_addr)
                `ADCSC_CTRL_OFS: begin
                    st_next.ljst = hwdata[`ADCSC_BIT_LJST];
                    if (!hwdata[`ADCSC_BIT_WIN]) begin
                        st_next.window_flag = 1'b0;
                    end
                    st_next.start_source_field =
                        hwdata[`ADCSC_BIT_SRC_HI:`ADCSC_BIT_SRC_LO];
                    st_next.tracking_mode_select = hwdata[`ADCSC_BIT_TRACK];
                    // Only a one in software mode starts; zero does nothing
                    sw_start = hwdata[`ADCSC_BIT_BUSY] &&
                        (st_reg.start_source_field == ADCSC_SRC_SW);
                end
                `ADCSC_DONE_OFS: begin
                    if (!hwdata[`ADCSC_BIT_DONE]) begin
                        st_next.done_flag = 1'b0;
                    end
                end
                `ADCSC_CONV_OFS: begin
                    st_next.conv_cycles = hwdata[7:0];
                end
                default: begin
                    st_next.conv_cycles = st_reg.conv_cycles;
                end
            endcase
        end
        // Trigger decode from the source field
        unique case (adcsc_src_t'(st_reg.start_source_field))
            ADCSC_SRC_SW: trig = sw_start;
            ADCSC_SRC_T3: trig = timer3_overflow;
            ADCSC_SRC_PIN: trig = pin_rise;
            ADCSC_SRC_T2: trig = timer2_overflow;
        endcase
        // Sequencer; triggers during a conversion are ignored
        unique case (st_reg.state)
            ADCSC_IDLE: begin
                if (st_reg.tracking_mode_select &&
                    st_reg.start_source_field == ADCSC_SRC_PIN) begin
                    st_next.state = ADCSC_GATE;
                end else if (trig && st_reg.tracking_mode_select) begin
                    st_next.state = ADCSC_TRACK;
                    st_next.track_cnt = `ADCSC_TRACK_CLOCKS;
                end else if (trig) begin
                    st_next.state = ADCSC_CONV;
                    st_next.conv_cnt = st_reg.conv_cycles;
                    st_next.start_pulse = 1'b1;
                end
            end
            ADCSC_TRACK: begin
                // Counts converter clock ticks, not system clocks
                if (sar_clk_tick) begin
                    if (st_reg.track_cnt == 2'h1) begin
                        st_next.state = ADCSC_CONV;
                        st_next.conv_cnt = st_reg.conv_cycles;
                        st_next.start_pulse = 1'b1;
                    end else begin
                        st_next.track_cnt = st_reg.track_cnt - 2'h1;
                    end
                end
            end
            ADCSC_GATE: begin
                // Tracks while the pin is low; rising edge converts
                if (!(st_reg.tracking_mode_select &&
                      st_reg.start_source_field == ADCSC_SRC_PIN)) begin
                    st_next.state = ADCSC_IDLE;
                end else if (pin_rise) begin
                    st_next.state = ADCSC_CONV;
                    st_next.conv_cnt = st_reg.conv_cycles;
                    st_next.start_pulse = 1'b1;
                end
            end
            ADCSC_CONV: begin
                if (sar_clk_tick) begin
                    if (st_reg.conv_cnt <= 8'h1) begin
                        st_next.state = ADCSC_IDLE;
                        st_next.done_flag = 1'b1;
                    end else begin
                        st_next.conv_cnt = st_reg.conv_cnt - 8'h1;
                    end
                end
            end
            default: begin
                st_next.state = ADCSC_IDLE;
            end
        endcase
        st_next.tracking = (st_next.state == ADCSC_TRACK) ||
            (st_next.state == ADCSC_GATE && !pin_level);
        // Match set wins over a same-cycle software clear
        if (window_match) begin
            st_next.window_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.state <= ADCSC_IDLE;
            st_reg.start_source_field <= `ADCSC_SRC_RESET;
            st_reg.conv_cycles <= `ADCSC_CONV_CYC_RESET;
            // Matches the synchroniser's reset level: no false rising edge
            st_reg.pin_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops; bus ready and response tied off
    assign hrdata = st_reg.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign tracking_active = st_reg.tracking;
    assign conversion_start = st_reg.start_pulse;
    assign conversion_busy_flag = st_reg.state[3];
    assign conversion_done_flag = st_reg.done_flag;
    assign window_match_flag = st_reg.window_flag;
    assign left_justify_select = st_reg.ljst;
endmodule // adcsc_top

// ### verif/adcsc_top_assertions.sv
module adcsc_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic tracking_active,
    input wire logic conversion_start,
    input wire logic conversion_busy_flag,
    input wire logic conversion_done_flag,
    input wire logic window_match,
    input wire logic window_match_flag,
    input wire logic left_justify_select
);
    // One clock domain, so clock and reset are given once
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A conversion opens with a lone start strobe
    sequence s_begin;
        conversion_start ##1 !conversion_start;
    endsequence
    a_busy_rise_start: assert property ($rose(conversion_busy_flag) |-> s_begin)
        else $error("busy rose without start");
    a_start_single: assert property (conversion_start |=> !conversion_start)
        else $error("start strobe too long");
    a_done_on_fall: assert property (
        $fell(conversion_busy_flag) |-> ##[0:1] conversion_done_flag)
        else $error("done missing at end");
    a_done_sw_clear: assert property ($fell(conversion_done_flag) |-> $past(hwrite, 2))
        else $error("done cleared by itself");
    a_win_sets: assert property (window_match |=> window_match_flag)
        else $error("window flag not set");
    a_win_sw_clear: assert property ($fell(window_match_flag) |-> $past(hwrite, 2))
        else $error("window flag cleared by itself");
    a_ljst_by_write: assert property (
        $changed(left_justify_select) |-> $past(hwrite, 2))
        else $error("justify changed without write");
    a_track_then_conv: assert property (
        $fell(tracking_active) |-> ##[0:2] conversion_start)
        else $error("no conversion after tracking");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
endmodule // adcsc_chk

bind adcsc_top adcsc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hwrite(hwrite),
    .hreadyout(hreadyout), .hresp(hresp), .tracking_active(tracking_active),
    .conversion_start(conversion_start), .conversion_busy_flag(conversion_busy_flag),
    .conversion_done_flag(conversion_done_flag), .window_match(window_match),
    .window_match_flag(window_match_flag), .left_justify_select(left_justify_select));

// ### verif/adcsc_far_model.sv
module adcsc_far_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic t3_req,
    input wire logic t2_req,
    input wire logic pin_req,
    output logic sar_clk_tick,
    output logic timer3_overflow,
    output logic timer2_overflow,
    output logic external_convert_start
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg; // Converter clock divider
    // Converter clock ticks every fourth cycle, so tracking is not one cycle per tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign sar_clk_tick = (div_reg == 2'h3);
    // Timer overflows are one-cycle pulses
    assign timer3_overflow = t3_req;
    assign timer2_overflow = t2_req;
    // Pin moves off the clock grid, as a real asynchronous input would
    assign #3 external_convert_start = pin_req;
endmodule // adcsc_far_model

// ### verif/adcsc_top_tb_top.sv
module adcsc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdat, cfg;
    logic tick, t3, t2, pin, t3_req, t2_req, pin_req, win;
    logic trk, cstart, busy, done, winf, ljst;
    int fail_count, n_tests, trk_ticks;
    assign hready = hreadyout; // Single slave drives the bus ready
    adcsc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sar_clk_tick(tick),
        .timer3_overflow(t3), .timer2_overflow(t2), .external_convert_start(pin),
        .window_match(win), .tracking_active(trk), .conversion_start(cstart),
        .conversion_busy_flag(busy), .conversion_done_flag(done),
        .window_match_flag(winf), .left_justify_select(ljst));
    adcsc_far_model far (.hclk(hclk), .hresetn(hresetn), .t3_req(t3_req), .t2_req(t2_req),
        .pin_req(pin_req), .sar_clk_tick(tick), .timer3_overflow(t3),
        .timer2_overflow(t2), .external_convert_start(pin));
    // Free-running 125 MHz clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Converter ticks seen while tracking
    always @(posedge hclk) begin
        if (trk === 1'b1 && tick === 1'b1) trk_ticks++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single AHB transfer; read data lands in rdat
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        print_verdict();
    end
    initial begin
        {hresetn, hwrite, t3_req, t2_req, win, htrans, haddr, hwdata} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        pin_req = 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 32'h08, 32'h0);
        chk(rdat, 32'h10);
        xfer(1'b1, 32'h08, 32'h4); // Short conversions keep the run brief
        xfer(1'b0, 32'h0c, 32'h0);
        chk(rdat, 32'h0);
        // Every tracking mode against every start source
        for (int m = 0; m < 8; m++) begin
            cfg = {26'h0, m[2], 1'b0, m[1:0], 2'h0};
            xfer(1'b1, 32'h0, cfg);
            if (m[1:0] != 2'h0) begin
                xfer(1'b1, 32'h0, cfg | 32'h10);
                repeat (20) @(posedge hclk);
                chk(busy, 1'b0);
            end
            trk_ticks = 0;
            case (m[1:0])
                2'h0: xfer(1'b1, 32'h0, cfg | 32'h10);
                2'h1: t3_req <= 1'b1;
                2'h2: pin_req <= 1'b0;
                default: t2_req <= 1'b1;
            endcase
            @(posedge hclk);
            {t3_req, t2_req} <= 2'h0;
            if (m == 0) begin
                chk(cstart, 1'b1);
                xfer(1'b0, 32'h0, 32'h0);
                chk(rdat[4], 1'b1);
            end
            if (m[1:0] == 2'h2) begin
                repeat (12) @(posedge hclk);
                chk(trk, m[2]);
                pin_req <= 1'b1;
            end
            for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge hclk);
            chk(done, 1'b1);
            chk(busy, 1'b0);
            if (m[1:0] != 2'h2) chk(trk_ticks, m[2] ? 3 : 0);
            xfer(1'b1, 32'h04, 32'h0);
            @(posedge hclk);
            chk(done, 1'b0);
        end
        // Window flag holds until software clears it; bit 0 is the justify select
        win <= 1'b1;
        @(posedge hclk);
        win <= 1'b0;
        repeat (5) @(posedge hclk);
        xfer(1'b0, 32'h0, 32'h0);
        chk(rdat[1], 1'b1);
        xfer(1'b1, 32'h0, 32'h3);
        @(posedge hclk);
        chk({winf, ljst}, 2'h3);
        xfer(1'b1, 32'h0, 32'h0);
        @(posedge hclk);
        chk({winf, ljst}, 2'h0);
        print_verdict();
    end
endmodule // adcsc_top_tb_top
